// [common/mia_pkg.sv]
`default_nettype none
package mia_pkg;

    // =========================================================
    // Register byte addresses
    localparam logic [31:0] MIA_OFF_IRQ_STA = 32'hFFFF0000;
    localparam logic [31:0] MIA_OFF_IRQ_SIG = 32'hFFFF0004;
    localparam logic [31:0] MIA_OFF_IRQ_EN  = 32'hFFFF0008;
    localparam logic [31:0] MIA_OFF_IRQ_CLR = 32'hFFFF000C;
    localparam logic [31:0] MIA_OFF_FIQ_STA = 32'hFFFF0100;
    localparam logic [31:0] MIA_OFF_FIQ_SIG = 32'hFFFF0104;
    localparam logic [31:0] MIA_OFF_FIQ_EN  = 32'hFFFF0108;
    localparam logic [31:0] MIA_OFF_FIQ_CLR = 32'hFFFF010C;
    localparam logic [31:0] MIA_OFF_SEL     = 32'hFFFF0020;
    localparam logic [31:0] MIA_OFF_SWI     = 32'hFFFF0024;
    localparam logic [31:0] MIA_OFF_EVT_STA = 32'hFFFF0028;
    localparam logic [31:0] MIA_OFF_EVT_MSK = 32'hFFFF002C;

    // =========================================================
    // Field layout
    localparam int MIA_NSRC     = 23;
    localparam int MIA_BIT_ANY  = 0;
    localparam int MIA_BIT_SWI  = 1;
    localparam int MIA_BIT_EXT0 = 15;
    localparam int MIA_BIT_EXT1 = 18;
    localparam int MIA_BIT_EXT2 = 21;
    localparam int MIA_BIT_EXT3 = 22;
    localparam int MIA_BIT_PWM  = 23;
    localparam int MIA_SEL_W    = 5;
    localparam int MIA_EVT_W    = 2;
    localparam logic [31:0] MIA_IRQ_BITS = 32'h00FFFFFE;
    localparam logic [31:0] MIA_FIQ_BITS = 32'h00FFFFFF;

    // =========================================================
    // Reset values and bus answers
    localparam logic [31:0] MIA_EN_RST  = 32'h00000000;
    localparam logic [MIA_SEL_W-1:0] MIA_SEL_RST = 5'h00;
    localparam logic [MIA_EVT_W-1:0] MIA_EVT_RST = 2'h0;
    localparam logic [1:0]  MIA_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  MIA_RESP_SLVERR = 2'h2;

    // On-chip peripheral request levels, same clock as the block
    typedef struct packed {
        logic pwm_sync;
        logic pwm_trip;
        logic pla_external_request_one;
        logic pla_external_request_zero;
        logic supply_monitor;
        logic comparator;
        logic uart;
        logic spi_master;
        logic spi_slave;
        logic i2c1_master;
        logic i2c0_master;
        logic i2c0_slave;
        logic pll_lock;
        logic adc;
        logic flash;
        logic watchdog;
        logic wakeup_timer;
        logic timer1;
        logic timer0;
    } mia_src_t;

    typedef struct packed {
        logic [3:0]           ext_s1;
        logic [3:0]           ext_s2;
        logic [3:0]           ext_s3;
        logic [3:0]           ext_q;
        logic [31:0]          irq_raw;
        logic [31:0]          fiq_raw;
        logic [31:0]          irq_en;
        logic [31:0]          fiq_en;
        logic                 software_interrupt;
        logic [MIA_SEL_W-1:0] sel;
        logic                 sel_hit;
        logic [MIA_EVT_W-1:0] evt_sta;
        logic [MIA_EVT_W-1:0] evt_msk;
        logic                 irq_out;
        logic                 fiq_out;
        logic                 aw_have;
        logic                 w_have;
        logic [31:0]          awaddr;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } mia_state_t;

endpackage : mia_pkg
`default_nettype wire

// [rtl/mia_top.sv]
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Take 23 sources, four from pins
// - Sources reach core as normal or fast
// - Twelve registers: two banks, select, software interrupt, event status and mask
// - Same bits per bank; bits 0 and 23 differ
// - Fast bit 0 ORs all sources
// - Bit 1 software interrupt, bits 2 to 14 fixed peripheral map
// - Masked status is raw AND enable
// - No priority encoder, no vectors
// - Normal line ORs all status bits
// - Raw register follows source levels, read-only
// - Enable one passes, zero blocks
// - Writing zero to enable changes nothing
// - Clear register drops only written ones
module mia_top
    import mia_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Interrupt sources
    input  wire mia_src_t    src,
    input  wire logic [3:0]  ext_req,
    // AXI4-Lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Core side
    output logic             normal_interrupt_line,
    output logic             fast_interrupt_line,
    output logic             selected_source_active,
    output logic             event_irq
);

    // =========================================================
    // State
    mia_state_t st;
    mia_state_t next_st;

    logic [31:0] src_vec;
    logic [31:0] irq_sta;
    logic [31:0] fiq_sta;
    logic [31:0] wmask;
    logic [31:0] waddr;
    logic [31:0] raddr;
    logic        wr_go;
    logic        rd_go;
    logic [1:0]  evt_set;
    logic [1:0]  evt_clr;

    // =========================================================
    // Byte lanes of a write
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : lane_mask

    // =========================================================
    // Combinational views of registered state
    always_comb
    begin
        irq_sta = st.irq_raw & st.irq_en;
        fiq_sta = st.fiq_raw & st.fiq_en;
    end

    // Bus views: word-aligned addresses and the lanes a write may touch
    always_comb
    begin
        wmask   = st.wdata & lane_mask(st.wstrb);
        waddr   = {st.awaddr[31:2], 2'b00};
        raddr   = {s_axi_araddr[31:2], 2'b00};
        // The answer waits for both halves of the write
        wr_go   = st.aw_have && st.w_have && !st.bvalid;
        rd_go   = s_axi_arvalid && !st.rvalid;
    end

    // =========================================================
    // Source bit map shared by both banks, bits 0 and 23 excepted
    always_comb
    begin
        src_vec               = 32'h00000000;
        src_vec[MIA_BIT_SWI]  = st.software_interrupt;
        src_vec[2]            = src.timer0;
        src_vec[3]            = src.timer1;
        src_vec[4]            = src.wakeup_timer;
        src_vec[5]            = src.watchdog;
        src_vec[6]            = src.flash;
        src_vec[7]            = src.adc;
        src_vec[8]            = src.pll_lock;
        src_vec[9]            = src.i2c0_slave;
        src_vec[10]           = src.i2c0_master;
        src_vec[11]           = src.i2c1_master;
        src_vec[12]           = src.spi_slave;
        src_vec[13]           = src.spi_master;
        src_vec[14]           = src.uart;
        src_vec[MIA_BIT_EXT0] = st.ext_q[0];
        src_vec[16]           = src.comparator;
        src_vec[17]           = src.supply_monitor;
        src_vec[MIA_BIT_EXT1] = st.ext_q[1];
        src_vec[19]           = src.pla_external_request_zero;
        src_vec[20]           = src.pla_external_request_one;
        src_vec[MIA_BIT_EXT2] = st.ext_q[2];
        src_vec[MIA_BIT_EXT3] = st.ext_q[3];
    end

    // =========================================================
    // Next state
    always_comb
    begin
        next_st = st;
        evt_set = MIA_EVT_RST;
        evt_clr = MIA_EVT_RST;

        // Pin requests: three stages, change accepted on agreement
        next_st.ext_s1 = ext_req;
        next_st.ext_s2 = st.ext_s1;
        next_st.ext_s3 = st.ext_s2;
        for (int i = 0; i < 4; i++)
        begin
            if (st.ext_s2[i] == st.ext_s3[i])
            begin
                next_st.ext_q[i] = st.ext_s3[i];
            end
        end

        // Raw views follow the levels; no latching, so a request
        // drops only when its peripheral clears it
        next_st.irq_raw = src_vec;
        next_st.irq_raw[MIA_BIT_PWM] = src.pwm_trip;
        next_st.fiq_raw = src_vec;
        next_st.fiq_raw[MIA_BIT_PWM] = src.pwm_sync;
        next_st.fiq_raw[MIA_BIT_ANY] =
            (|src_vec) | src.pwm_trip | src.pwm_sync;

        // Registered lines; software sorts priority from status
        next_st.irq_out = |irq_sta;
        next_st.fiq_out = |fiq_sta;
        // The raw bit picked by the select register, ORed across both banks, driven on selected_source_active
        next_st.sel_hit = st.irq_raw[st.sel] | st.fiq_raw[st.sel];

        // Events mark the rising step of each line only
        evt_set[0] = next_st.irq_out && !st.irq_out;
        evt_set[1] = next_st.fiq_out && !st.fiq_out;

        // =========================================================
        // Write channel: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_st.aw_have = 1'b1;
            next_st.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_st.w_have = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
        end

        if (wr_go)
        begin
            next_st.aw_have = 1'b0;
            next_st.w_have  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = MIA_RESP_OKAY;
            case (waddr)
                MIA_OFF_IRQ_EN:
                begin
                    // Zeros leave the mask alone
                    next_st.irq_en = st.irq_en
                        | (wmask & MIA_IRQ_BITS);
                end
                MIA_OFF_IRQ_CLR:
                begin
                    next_st.irq_en = st.irq_en & ~wmask;
                end
                MIA_OFF_FIQ_EN:
                begin
                    next_st.fiq_en = st.fiq_en
                        | (wmask & MIA_FIQ_BITS);
                end
                MIA_OFF_FIQ_CLR:
                begin
                    next_st.fiq_en = st.fiq_en & ~wmask;
                end
                MIA_OFF_SEL:
                begin
                    if (st.wstrb[0])
                    begin
                        next_st.sel = st.wdata[MIA_SEL_W-1:0];
                    end
                end
                MIA_OFF_SWI:
                begin
                    if (st.wstrb[0])
                    begin
                        next_st.software_interrupt = st.wdata[0];
                    end
                end
                MIA_OFF_EVT_MSK:
                begin
                    if (st.wstrb[0])
                    begin
                        next_st.evt_msk = st.wdata[MIA_EVT_W-1:0];
                    end
                end
                // Read-only registers ignore writes quietly
                MIA_OFF_IRQ_STA,
                MIA_OFF_IRQ_SIG,
                MIA_OFF_FIQ_STA,
                MIA_OFF_FIQ_SIG,
                MIA_OFF_EVT_STA:
                begin
                    next_st.bresp = MIA_RESP_OKAY;
                end
                default:
                begin
                    next_st.bresp = MIA_RESP_SLVERR;
                end
            endcase
        end
        else if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid = 1'b0;
        end

        // =========================================================
        // Read channel: one cycle to rvalid
        if (rd_go)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = MIA_RESP_OKAY;
            case (raddr)
                MIA_OFF_IRQ_STA:
                begin
                    next_st.rdata = irq_sta;
                end
                MIA_OFF_IRQ_SIG:
                begin
                    next_st.rdata = st.irq_raw;
                end
                MIA_OFF_IRQ_EN:
                begin
                    next_st.rdata = st.irq_en;
                end
                MIA_OFF_FIQ_STA:
                begin
                    next_st.rdata = fiq_sta;
                end
                MIA_OFF_FIQ_SIG:
                begin
                    next_st.rdata = st.fiq_raw;
                end
                MIA_OFF_FIQ_EN:
                begin
                    next_st.rdata = st.fiq_en;
                end
                // Clear registers are write-only and read as zero
                MIA_OFF_IRQ_CLR:
                begin
                    next_st.rdata = 32'h00000000;
                end
                MIA_OFF_FIQ_CLR:
                begin
                    next_st.rdata = 32'h00000000;
                end
                MIA_OFF_SEL:
                begin
                    next_st.rdata = {27'h0000000, st.sel};
                end
                MIA_OFF_SWI:
                begin
                    next_st.rdata = {31'h00000000, st.software_interrupt};
                end
                MIA_OFF_EVT_STA:
                begin
                    // The read itself clears what it returns
                    next_st.rdata = {30'h00000000, st.evt_sta};
                    evt_clr       = st.evt_sta;
                end
                MIA_OFF_EVT_MSK:
                begin
                    next_st.rdata = {30'h00000000, st.evt_msk};
                end
                default:
                begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = MIA_RESP_SLVERR;
                end
            endcase
        end
        else if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
        end

        // A new event in the clearing cycle survives the read
        next_st.evt_sta = (st.evt_sta & ~evt_clr) | evt_set;
    end

    // =========================================================
    // Registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            // Enables start cleared: no source reaches either interrupt line until software opts in
            st         <= '0;
            st.irq_en  <= MIA_EN_RST;
            st.fiq_en  <= MIA_EN_RST;
            st.sel     <= MIA_SEL_RST;
            st.evt_sta <= MIA_EVT_RST;
            st.evt_msk <= MIA_EVT_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // =========================================================
    // Outputs
    // Ready drops while a word is held, so a second write waits for the answer
    assign s_axi_awready = !st.aw_have && !st.bvalid;
    assign s_axi_wready  = !st.w_have && !st.bvalid;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;

    // =========================================================
    // Core side
    assign normal_interrupt_line  = st.irq_out;
    assign fast_interrupt_line    = st.fiq_out;
    assign selected_source_active = st.sel_hit;
    assign event_irq              = |(st.evt_sta & st.evt_msk);

endmodule : mia_top
`default_nettype wire

// [dv/mia_properties.sv]
`timescale 1ns/10ps
`default_nettype none
// ====
// Bus handshake and core line checks
module mia_checker
    import mia_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Core side
    input wire logic        normal_interrupt_line,
    input wire logic        fast_interrupt_line
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_ar_free: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready does not mirror rvalid");
    chk_b_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped");
    chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == MIA_RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("refused read carries data");
    chk_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_wr_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    chk_rst_quiet: assert property ($rose(aresetn) |-> !normal_interrupt_line
        && !fast_interrupt_line && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active out of reset");
endmodule : mia_checker

bind mia_top mia_checker u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .normal_interrupt_line(normal_interrupt_line), .fast_interrupt_line(fast_interrupt_line));
`default_nettype wire

// [dv/mia_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ====
// Core side: counts entries on each interrupt line
module mia_core_model (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Interrupt inputs of the core
    input  wire logic normal_line,
    input  wire logic fast_line,
    // Entries seen
    output var int    normal_rises,
    output var int    fast_rises
);
    logic prev_n;
    logic prev_f;
    // Lines are levels, so only a low-to-high step counts as a new entry
    always @(posedge aclk)
    begin
        prev_n <= aresetn && normal_line;
        prev_f <= aresetn && fast_line;
        if (!aresetn)
        begin
            normal_rises <= 0;
            fast_rises <= 0;
        end
        if (aresetn && normal_line && !prev_n)
            normal_rises <= normal_rises + 1;
        if (aresetn && fast_line && !prev_f)
            fast_rises <= fast_rises + 1;
    end
endmodule : mia_core_model
`default_nettype wire

// [dv/masked_irq_aggregator_tb.sv]
`timescale 1ns/10ps
`default_nettype none
// ====
// Stimulus and expectations
module masked_irq_aggregator_tb;
    import mia_pkg::*;
    localparam logic [31:0] ZREG [11] = '{MIA_OFF_IRQ_STA, MIA_OFF_IRQ_SIG, MIA_OFF_IRQ_EN,
        MIA_OFF_IRQ_CLR, MIA_OFF_FIQ_STA, MIA_OFF_FIQ_SIG, MIA_OFF_FIQ_EN, MIA_OFF_SEL,
        MIA_OFF_SWI, MIA_OFF_EVT_STA, MIA_OFF_EVT_MSK};
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    mia_src_t    src     = '0;
    logic [3:0]  ext_req = 4'h0;
    logic [31:0] awaddr  = 32'h0;
    logic [31:0] wdata   = 32'h0;
    logic [31:0] araddr  = 32'h0;
    logic [3:0]  wstrb   = 4'h0;
    logic [3:0]  strb    = 4'hF;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, nline, fline, sel_act, evt;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          bad_count = 0;
    int          compares  = 0;
    int          nrise, frise;

    always #5 aclk = ~aclk;

    mia_top u_dut (.aclk(aclk), .aresetn(aresetn), .src(src), .ext_req(ext_req),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .normal_interrupt_line(nline), .fast_interrupt_line(fline),
        .selected_source_active(sel_act), .event_irq(evt));
    mia_core_model u_core (.aclk(aclk), .aresetn(aresetn), .normal_line(nline),
        .fast_line(fline), .normal_rises(nrise), .fast_rises(frise));

    // ====
    // Checking and closing
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // Bit map of both banks; the fast bank's bit 0 is the OR of every source
    function automatic logic [31:0] exp_raw(input mia_src_t s, input logic [3:0] e,
        input logic sw, input logic fast);
        return {8'h00, fast ? s[18] : s[17], e[3], e[2], s[16], s[15], e[1], s[14], s[13],
            e[0], s[12:0], sw, fast && (|s || |e || sw)};
    endfunction : exp_raw

    // ====
    // Bus master: every change lands just after an edge
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic [2:0] t;
        awaddr <= a;
        wdata <= d;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            #1;
            t = {awvalid && awready, wvalid && wready, bvalid};
            r = bresp;
            @(posedge aclk);
            if (t[2])
                awvalid <= 1'b0;
            if (t[1])
                wvalid <= 1'b0;
        end while (!t[0]);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic [1:0] t;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            #1;
            t = {arvalid && arready, rvalid};
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (t[1])
                arvalid <= 1'b0;
        end while (!t[0]);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        check("read data", d, exp);
        check("read response", {30'h0, r}, {30'h0, MIA_RESP_OKAY});
    endtask : rdchk

    // ====
    // Main sequence
    initial
    begin
        logic [31:0] d, en_n, en_f, rn, rf, base, msk;
        logic [1:0]  r;
        logic        sw;
        logic [4:0]  sel;
        int          n0, f0;
        void'($urandom(32'h2FE3B101));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (ZREG[i])
            rdchk(ZREG[i], 32'h0);
        $display("reset values test done");
        for (int k = 0; k < 10; k++)
        begin
            en_n = (k == 0) ? 32'hFFFFFFFF : (k == 1) ? 32'h0 : $urandom();
            en_f = (k == 0) ? 32'hFFFFFFFF : (k == 1) ? 32'h0 : $urandom();
            sw = 1'($urandom());
            sel = 5'($urandom());
            wr(MIA_OFF_IRQ_CLR, 32'hFFFFFFFF, r);
            wr(MIA_OFF_FIQ_CLR, 32'hFFFFFFFF, r);
            wr(MIA_OFF_IRQ_EN, en_n, r);
            wr(MIA_OFF_FIQ_EN, en_f, r);
            wr(MIA_OFF_SWI, {31'h0, sw}, r);
            wr(MIA_OFF_SEL, {27'h0, sel}, r);
            src <= mia_src_t'($urandom());
            ext_req <= 4'($urandom());
            repeat (8) @(posedge aclk);
            rn = exp_raw(src, ext_req, sw, 1'b0);
            rf = exp_raw(src, ext_req, sw, 1'b1);
            rdchk(MIA_OFF_IRQ_SIG, rn);
            rdchk(MIA_OFF_FIQ_SIG, rf);
            rdchk(MIA_OFF_IRQ_EN, en_n & MIA_IRQ_BITS);
            rdchk(MIA_OFF_IRQ_STA, rn & en_n);
            rdchk(MIA_OFF_FIQ_STA, rf & en_f & MIA_FIQ_BITS);
            rdchk(MIA_OFF_SEL, {27'h0, sel});
            #1;
            check("normal line", {31'h0, nline}, {31'h0, |(rn & en_n)});
            check("fast line", {31'h0, fline}, {31'h0, |(rf & en_f & MIA_FIQ_BITS)});
            check("selected", {31'h0, sel_act}, {31'h0, rn[sel] | rf[sel]});
            @(posedge aclk);
        end
        $display("random source test done");
        for (int b = 0; b < 2; b++)
        begin
            base = b ? 32'h100 : 32'h0;
            msk = b ? MIA_FIQ_BITS : MIA_IRQ_BITS;
            wr(MIA_OFF_IRQ_EN + base, 32'hFFFFFFFF, r);
            wr(MIA_OFF_IRQ_EN + base, 32'h0, r);
            rdchk(MIA_OFF_IRQ_EN + base, msk);
            wr(MIA_OFF_IRQ_CLR + base, 32'h00F0F00D, r);
            rdchk(MIA_OFF_IRQ_EN + base, msk & ~32'h00F0F00D);
            rdchk(MIA_OFF_IRQ_CLR + base, 32'h0);
        end
        $display("enable set and clear test done");
        wr(32'hFFFF0040, 32'h1, r);
        check("unmapped write", {30'h0, r}, {30'h0, MIA_RESP_SLVERR});
        rd(32'hFFFF0040, d, r);
        check("unmapped read", {r, d[29:0]}, {MIA_RESP_SLVERR, 30'h0});
        wr(MIA_OFF_IRQ_SIG, 32'hFFFFFFFF, r);
        rdchk(MIA_OFF_IRQ_SIG, rn);
        strb = 4'h2;
        wr(MIA_OFF_IRQ_CLR, 32'hFFFFFFFF, r);
        strb = 4'hF;
        rdchk(MIA_OFF_IRQ_EN, MIA_IRQ_BITS & ~32'h00F0F00D & ~32'h0000FF00);
        $display("refusal test done");
        wr(MIA_OFF_IRQ_CLR, 32'hFFFFFFFF, r);
        wr(MIA_OFF_FIQ_CLR, 32'hFFFFFFFF, r);
        wr(MIA_OFF_SWI, 32'h0, r);
        src <= '0;
        ext_req <= 4'h0;
        wr(MIA_OFF_IRQ_EN, 32'h00000004, r);
        wr(MIA_OFF_FIQ_EN, 32'h00000004, r);
        wr(MIA_OFF_EVT_MSK, 32'h3, r);
        repeat (8) @(posedge aclk);
        rd(MIA_OFF_EVT_STA, d, r);
        n0 = nrise;
        f0 = frise;
        src <= mia_src_t'(19'h00001);
        @(posedge aclk);
        #1;
        check("line one edge on", {31'h0, nline}, 32'h0);
        @(posedge aclk);
        #1;
        check("line two edges on", {30'h0, nline, fline}, 32'h3);
        repeat (3) @(posedge aclk);
        check("event line", {31'h0, evt}, 32'h1);
        check("core entries", nrise, n0 + 1);
        check("core fast entries", frise, f0 + 1);
        rdchk(MIA_OFF_EVT_STA, 32'h3);
        repeat (2) @(posedge aclk);
        #1;
        check("event after read", {31'h0, evt}, 32'h0);
        $display("latency and event test done");
        tally_and_finish();
    end

    // Whole run is under a thousand cycles; this margin only catches a hang
    initial
    begin
        #200000;
        bad_count++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule : masked_irq_aggregator_tb
`default_nettype wire
